/* File: design/acss_pkg.sv */
// package: constants, modes and state layouts of the serial channel
package acss_pkg;

	// width of the programmable baud reload value
	localparam int ACSS_BAUD_W = 13;

	// async oversampling: sixteen baud ticks per bit, centre at tick 8
	localparam logic [3:0] ACSS_OVS_LAST = 4'hF;
	localparam logic [3:0] ACSS_OVS_MID  = 4'h7;

	// bit counters: last index of a sync byte and of the 8 data bits
	localparam logic [3:0] ACSS_SYNC_LAST = 4'h7;
	localparam logic [3:0] ACSS_DATA_LAST = 4'h7;
	// async frame: start plus 8 data bits puts the first stop at index 9
	localparam logic [3:0] ACSS_ASYNC_BASE = 4'h9;
	localparam logic [3:0] ACSS_CNT_ZERO  = 4'h0;
	localparam logic [3:0] ACSS_CNT_ONE   = 4'h1;

	typedef logic [8:0] acss_word_t;

	// frame formats
	typedef enum logic [1:0] {
		ACSS_SYNC8      = 2'h0,
		ACSS_ASYNC8     = 2'h1,
		ACSS_ASYNC9     = 2'h3,
		ACSS_ASYNC_WAKE = 2'h2
	} acss_mode_e;

	typedef enum logic [1:0] {
		ACSS_TX_IDLE  = 2'h0,
		ACSS_TX_ASYNC = 2'h1,
		ACSS_TX_SYNC  = 2'h2
	} acss_tx_st_e;

	typedef enum logic [1:0] {
		ACSS_RX_IDLE  = 2'h0,
		ACSS_RX_START = 2'h1,
		ACSS_RX_DATA  = 2'h3,
		ACSS_RX_STOP  = 2'h2
	} acss_rx_st_e;

	// configuration bits, held steady by software while a frame runs
	typedef struct packed {
		acss_mode_e             mode;
		logic                   stop2;
		logic                   par_en;
		logic                   par_odd;
		logic                   frm_chk;
		logic                   wake_filt;
		logic                   loop;
		logic                   rx_en;
		logic [ACSS_BAUD_W-1:0] reload;
	} acss_cfg_s;

	// sticky error flags
	typedef struct packed {
		logic par;
		logic frm;
		logic ovr;
	} acss_err_s;

	// one-cycle interrupt request pulses
	typedef struct packed {
		logic tx_empty;
		logic tx_done;
		logic rx;
		logic err;
	} acss_irq_s;

	typedef struct packed {
		logic meta;
		logic stable;
	} acss_sync_s;

	typedef struct packed {
		logic [ACSS_BAUD_W-1:0] cnt;
		logic                   tick;
	} acss_baud_s;

	typedef struct packed {
		acss_tx_st_e tx_st;
		logic [11:0] tx_sh;
		logic [3:0]  tx_cnt;
		logic [3:0]  tx_ph;
		logic        tx_dir;
		logic        sclk;
		acss_word_t  tx_buf;
		logic        tx_full;
		logic        txd;
		logic        rxd_oe;
		acss_rx_st_e rx_st;
		acss_word_t  rx_sh;
		logic [3:0]  rx_cnt;
		logic [3:0]  rx_ph;
		logic        rx_prev;
		acss_word_t  rx_buf;
		logic        rx_full;
		acss_err_s   err;
		acss_irq_s   irq;
	} acss_state_s;

	// idle lines are high, nothing buffered, no flags
	localparam acss_state_s ACSS_STATE_RST = '{
		tx_st:   ACSS_TX_IDLE,
		tx_sh:   12'hFFF,
		tx_cnt:  4'h0,
		tx_ph:   4'h0,
		tx_dir:  1'b0,
		sclk:    1'b1,
		tx_buf:  9'h000,
		tx_full: 1'b0,
		txd:     1'b1,
		rxd_oe:  1'b0,
		rx_st:   ACSS_RX_IDLE,
		rx_sh:   9'h000,
		rx_cnt:  4'h0,
		rx_ph:   4'h0,
		rx_prev: 1'b1,
		rx_buf:  9'h000,
		rx_full: 1'b0,
		err:     3'h0,
		irq:     4'h0
	};

endpackage

/* File: design/acss_sync2.sv */
// module: two-flop synchroniser for a pin input
`timescale 1ns/100ps
module acss_sync2
	import acss_pkg::*;
(
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic pin_in,
	output logic      sync_out
);

	acss_sync_s s_q;
	acss_sync_s s_d;

	// the first stage is read only by the second stage
	always_comb
	begin
		s_d.meta = pin_in;
		s_d.stable = s_q.meta;
	end

	// resets to the idle line level
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			s_q <= 2'h3;
		else
			s_q <= s_d;
	end

	assign sync_out = s_q.stable;

endmodule

/* File: design/acss_baud.sv */
// module: reloading baud rate tick generator
`timescale 1ns/100ps
module acss_baud
	import acss_pkg::*;
(
	input  wire logic                   core_clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic [ACSS_BAUD_W-1:0] reload_in,
	output logic                        tick_out
);

	acss_baud_s s_q;
	acss_baud_s s_d;

	// tick once every reload+1 clocks; free running so any rate
	// comes from the core clock without touching the oscillator
	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt == '0)
		begin
			s_d.cnt = reload_in;
			s_d.tick = 1'b1;
		end
		else
			s_d.cnt = s_q.cnt - 1'b1;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick_out = s_q.tick;

endmodule

/* File: design/acss_channel.sv */
// module: asynchronous / synchronous serial channel core
//
// Operation
// R1 - full-duplex async up to 781 kBaud
// R2 - half-duplex sync up to 3.1 MBaud
// R3 - start, 8 or 9 data, 1-2 stop
// R4 - 8 data plus wake-up address bit mode
// R5 - sync mode drives own shift clock, bytes
// R6 - sync bytes always shifted LSB first
// R7 - loop-back feeds transmitter into own receiver
// R8 - parity generated on send, checked on receive
// R9 - flag framing error on missing stop bit
// R10 - overrun when new char lands unread
// R11 - own programmable baud rate generator
// R12 - primary instance gives four interrupt requests
// R13 - secondary instance same, three interrupt requests
// R14 - receive buffer holds char until read; an overrun overwrites it with the new char
`timescale 1ns/100ps
module acss_channel
	import acss_pkg::*;
#(
	parameter bit SECONDARY = 1'b0
)(
	input  wire logic       core_clk_in,
	input  wire logic       rst_n_in,
	input  wire acss_cfg_s  cfg_in,
	input  wire acss_word_t tx_data_in,
	input  wire logic       tx_valid_in,
	output logic            tx_ready_out,
	output acss_word_t      rx_data_out,
	output logic            rx_full_out,
	input  wire logic       rx_read_in,
	output acss_err_s       err_out,
	input  wire logic       err_clr_in,
	output acss_irq_s       irq_out,
	output logic            txd_out,
	input  wire logic       rxd_in,
	output logic            rxd_out,
	output logic            rxd_oe_out
);

	acss_state_s s_q;
	acss_state_s s_d;

	logic       tick;
	logic       rxd_sync;
	logic       rx_line;
	logic       async_mode;
	logic       use_par;
	logic       n9;
	logic       tx_ninth;
	logic       rx_done;
	logic       frm_bad;
	logic       keep;
	logic       par_bad;
	logic [3:0] rx_last;
	acss_word_t word;

	// baud ticks from the core clock
	acss_baud u_baud (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.reload_in   (cfg_in.reload),
		.tick_out    (tick)
	); // R11

	// the serial data pin is asynchronous to the core clock
	acss_sync2 u_rxd_sync (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (rxd_in),
		.sync_out    (rxd_sync)
	);

	// frame shape decoded from the configuration
	assign async_mode = (cfg_in.mode != ACSS_SYNC8);
	// the wake-up bit owns the ninth slot, so parity stays out of it
	assign use_par = cfg_in.par_en && (cfg_in.mode != ACSS_ASYNC_WAKE); // R8
	assign n9 = (cfg_in.mode != ACSS_ASYNC8) || use_par; // R3
	assign tx_ninth = use_par ? (^s_q.tx_buf[7:0] ^ cfg_in.par_odd)
		: s_q.tx_buf[8]; // R8
	assign rx_last = ACSS_DATA_LAST + {3'h0, n9};

	// loop-back takes the transmit shifter output, pins stay quiet
	assign rx_line = cfg_in.loop ? s_q.tx_sh[0] : rxd_sync; // R7

	// next-state logic for transmitter, receiver and flags
	always_comb
	begin
		s_d = s_q;
		s_d.irq = '0;
		s_d.rx_prev = rx_line;
		rx_done = 1'b0;
		frm_bad = 1'b0;
		// a read frees the buffer; a store later in this cycle wins
		s_d.rx_full = s_q.rx_full & ~rx_read_in;
		if (err_clr_in)
			s_d.err = '0;

		// software hands over a character while the holding buffer is free
		if (tx_valid_in && !s_q.tx_full)
		begin
			s_d.tx_buf = tx_data_in;
			s_d.tx_full = 1'b1;
		end

		// transmitter; in sync mode it also clocks receptions
		unique case (s_q.tx_st)
			ACSS_TX_IDLE:
			begin
				s_d.tx_ph = ACSS_CNT_ZERO;
				s_d.sclk = 1'b1;
				if (s_q.tx_full)
				begin
					s_d.tx_full = 1'b0;
					s_d.irq.tx_empty = ~SECONDARY; // R12 R13
					s_d.tx_dir = 1'b1;
					if (async_mode)
					begin
						// stop bits, ninth bit, data, start; unused ninth
						// slot falls into the stop bits
						s_d.tx_sh = n9
							? {2'h3, tx_ninth, s_q.tx_buf[7:0], 1'b0}
							: {3'h7, s_q.tx_buf[7:0], 1'b0}; // R3 R4
						s_d.tx_cnt = ACSS_ASYNC_BASE + {3'h0, n9}
							+ {3'h0, cfg_in.stop2}; // R3
						s_d.tx_st = ACSS_TX_ASYNC; // R1
					end
					else
					begin
						s_d.tx_sh = {4'hF, s_q.tx_buf[7:0]}; // R6
						s_d.tx_cnt = ACSS_SYNC_LAST; // R5
						s_d.tx_st = ACSS_TX_SYNC; // R2
					end
				end
				else if (!async_mode && cfg_in.rx_en)
				begin
					// half duplex: receive only while nothing waits to go
					s_d.tx_dir = 1'b0;
					s_d.tx_sh = 12'hFFF;
					s_d.tx_cnt = ACSS_SYNC_LAST;
					s_d.tx_st = ACSS_TX_SYNC; // R2
				end
			end

			ACSS_TX_ASYNC:
			begin
				if (tick)
				begin
					if (s_q.tx_ph == ACSS_OVS_LAST)
					begin
						s_d.tx_ph = ACSS_CNT_ZERO;
						if (s_q.tx_cnt == ACSS_CNT_ZERO)
						begin
							s_d.tx_st = ACSS_TX_IDLE;
							s_d.irq.tx_done = 1'b1;
						end
						else
						begin
							// shift in ones so the line idles high after
							s_d.tx_sh = {1'b1, s_q.tx_sh[11:1]};
							s_d.tx_cnt = s_q.tx_cnt - ACSS_CNT_ONE;
						end
					end
					else
						s_d.tx_ph = s_q.tx_ph + ACSS_CNT_ONE;
				end
			end

			ACSS_TX_SYNC:
			begin
				// one tick low, one tick high: data changes on the falling
				// edge and is sampled on the rising edge
				if (tick)
				begin
					if (s_q.sclk)
					begin
						s_d.sclk = 1'b0; // R5
						// the first bit is already out; later bits move on
						// the fall so they are settled at the rising edge
						if (s_q.tx_cnt != ACSS_SYNC_LAST)
							s_d.tx_sh = {1'b1, s_q.tx_sh[11:1]}; // R6
					end
					else
					begin
						s_d.sclk = 1'b1;
						if (!s_q.tx_dir || cfg_in.loop)
							s_d.rx_sh = {1'b0, rx_line, s_q.rx_sh[7:1]}; // R6
						if (s_q.tx_cnt == ACSS_CNT_ZERO)
						begin
							s_d.tx_st = ACSS_TX_IDLE;
							s_d.irq.tx_done = s_q.tx_dir;
							rx_done = !s_q.tx_dir || cfg_in.loop; // R7
						end
						else
							s_d.tx_cnt = s_q.tx_cnt - ACSS_CNT_ONE;
					end
				end
			end

			default:
				s_d.tx_st = ACSS_TX_IDLE;
		endcase

		// asynchronous receiver, independent of the transmitter
		unique case (s_q.rx_st)
			ACSS_RX_IDLE:
			begin
				s_d.rx_ph = ACSS_CNT_ZERO;
				s_d.rx_cnt = ACSS_CNT_ZERO;
				if (async_mode && cfg_in.rx_en && s_q.rx_prev && !rx_line)
					s_d.rx_st = ACSS_RX_START; // R1
			end

			ACSS_RX_START:
			begin
				// recheck at mid bit so a short glitch is not a frame
				if (tick)
				begin
					if (s_q.rx_ph == ACSS_OVS_MID)
					begin
						s_d.rx_ph = ACSS_CNT_ZERO;
						s_d.rx_st = rx_line ? ACSS_RX_IDLE : ACSS_RX_DATA;
					end
					else
						s_d.rx_ph = s_q.rx_ph + ACSS_CNT_ONE;
				end
			end

			ACSS_RX_DATA:
			begin
				if (tick)
				begin
					if (s_q.rx_ph == ACSS_OVS_LAST)
					begin
						s_d.rx_ph = ACSS_CNT_ZERO;
						s_d.rx_sh = {rx_line, s_q.rx_sh[8:1]};
						if (s_q.rx_cnt == rx_last)
							s_d.rx_st = ACSS_RX_STOP; // R3
						else
							s_d.rx_cnt = s_q.rx_cnt + ACSS_CNT_ONE;
					end
					else
						s_d.rx_ph = s_q.rx_ph + ACSS_CNT_ONE;
				end
			end

			ACSS_RX_STOP:
			begin
				// only the first stop bit is checked; a second one is idle
				if (tick)
				begin
					if (s_q.rx_ph == ACSS_OVS_LAST)
					begin
						s_d.rx_st = ACSS_RX_IDLE;
						frm_bad = cfg_in.frm_chk && !rx_line; // R9
						rx_done = 1'b1;
					end
					else
						s_d.rx_ph = s_q.rx_ph + ACSS_CNT_ONE;
				end
			end
		endcase

		// align the received word; an 8-bit async frame sits high
		if (!async_mode)
			word = {1'b0, s_d.rx_sh[7:0]};
		else if (n9)
			word = s_d.rx_sh;
		else
			word = {1'b0, s_d.rx_sh[8:1]};

		// address-only filter in wake-up mode drops data characters
		keep = !(async_mode && cfg_in.mode == ACSS_ASYNC_WAKE
			&& cfg_in.wake_filt && !word[8]); // R4
		par_bad = async_mode && use_par
			&& (word[8] != (^word[7:0] ^ cfg_in.par_odd)); // R8

		// store a completed character; flags set here beat the clear
		if (rx_done && keep)
		begin
			if (s_q.rx_full && !rx_read_in)
				s_d.err.ovr = 1'b1; // R10
			s_d.rx_buf = word; // R14
			s_d.rx_full = 1'b1; // R14
			s_d.irq.rx = 1'b1;
			if (par_bad)
				s_d.err.par = 1'b1; // R8
			if (frm_bad)
				s_d.err.frm = 1'b1; // R9
			s_d.irq.err = par_bad || frm_bad
				|| (s_q.rx_full && !rx_read_in); // R12
		end

		// pin levels; loop-back keeps the pins idle
		if (cfg_in.loop)
			s_d.txd = 1'b1; // R7
		else if (async_mode)
			s_d.txd = s_d.tx_sh[0];
		else
			s_d.txd = s_d.sclk; // R5
		s_d.rxd_oe = (s_d.tx_st == ACSS_TX_SYNC) && s_d.tx_dir
			&& !async_mode && !cfg_in.loop; // R2
	end

	// the whole state registers on every rising edge
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			s_q <= ACSS_STATE_RST;
		else
			s_q <= s_d;
	end

	// the holding buffer accepts while it is empty
	assign tx_ready_out = !s_q.tx_full;

	// user side and pins straight from the state register
	assign rx_data_out = s_q.rx_buf;
	assign rx_full_out = s_q.rx_full;
	assign err_out = s_q.err;
	assign irq_out = s_q.irq; // R12
	assign txd_out = s_q.txd;
	assign rxd_out = s_q.tx_sh[0];
	assign rxd_oe_out = s_q.rxd_oe;

endmodule

/* File: verif/acss_channel_sva.sv */
// checker: port-level properties of the serial channel
`timescale 1ns/100ps
module acss_channel_sva
	import acss_pkg::*;
#(
	parameter bit SECONDARY = 1'b0
)(
	input wire logic      core_clk_in,
	input wire logic      rst_n_in,
	input wire acss_cfg_s cfg_in,
	input wire logic      tx_valid_in,
	input wire logic      tx_ready_out,
	input wire logic      rx_full_out,
	input wire logic      rx_read_in,
	input wire acss_err_s err_out,
	input wire logic      err_clr_in,
	input wire acss_irq_s irq_out,
	input wire logic      txd_out,
	input wire logic      rxd_oe_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// a request taken by the holding buffer
	sequence s_take;
		tx_valid_in && tx_ready_out;
	endsequence

	// loop-back asked for on two edges running
	sequence s_loop;
		cfg_in.loop ##1 cfg_in.loop;
	endsequence

	a_take_blocks: assert property (s_take |=> !tx_ready_out)
		else $error("buffer still ready after a take");
	a_loop_line: assert property (s_loop |-> txd_out)
		else $error("line moved during loop-back");
	a_ovr_full: assert property ($rose(err_out.ovr) |-> rx_full_out
		&& irq_out.err)
		else $error("overrun without full buffer or request");
	a_rx_pulse: assert property (irq_out.rx |=> !irq_out.rx)
		else $error("receive request longer than one cycle");
	a_done_pulse: assert property (irq_out.tx_done
		|=> !irq_out.tx_done)
		else $error("transmit done request longer than one cycle");
	a_rx_full: assert property (irq_out.rx |-> rx_full_out)
		else $error("receive request with empty buffer");
	a_read_clr: assert property (rx_read_in |=> !rx_full_out
		|| irq_out.rx)
		else $error("read left buffer full");
	a_oe_sync: assert property (rxd_oe_out |-> !cfg_in.loop
		&& cfg_in.mode == ACSS_SYNC8)
		else $error("data pin driven outside sync mode");
	a_err_hold: assert property (err_out.par && !err_clr_in
		|=> err_out.par)
		else $error("parity flag dropped uncleared");
	a_sec_empty: assert property (irq_out.tx_empty |-> !SECONDARY
		&& tx_ready_out)
		else $error("bad buffer-empty request");
endmodule

bind acss_channel acss_channel_sva #(.SECONDARY(SECONDARY))
	acss_channel_sva_inst (.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in), .cfg_in(cfg_in), .tx_valid_in(tx_valid_in),
	.tx_ready_out(tx_ready_out), .rx_full_out(rx_full_out),
	.rx_read_in(rx_read_in), .err_out(err_out),
	.err_clr_in(err_clr_in), .irq_out(irq_out), .txd_out(txd_out),
	.rxd_oe_out(rxd_oe_out));

/* File: verif/acss_partner.sv */
// model: serial terminal on the far side of the channel
`timescale 1ns/100ps
module acss_partner
#(
	parameter int BIT_CLKS = 48
)(
	input  wire logic core_clk_in,
	input  wire logic line_in,
	input  wire logic sclk_in,
	input  wire logic sdat_in,
	output logic      line_out
);
	// idle line sits high between frames
	initial line_out = 1'h1;

	// raw frame, start bit first, each bit one bit time
	task automatic send(input logic [10:0] raw, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge core_clk_in);
			#1 line_out = raw[i];
			repeat (BIT_CLKS - 1) @(posedge core_clk_in);
		end
		@(posedge core_clk_in);
		#1 line_out = 1'h1;
	endtask

	// sample at bit centres after the falling start edge
	task automatic recv(output logic [10:0] raw, input int n);
		raw = '0;
		@(negedge line_in);
		repeat (BIT_CLKS / 2) @(posedge core_clk_in);
		for (int i = 0; i < n; i++)
		begin
			raw[i] = line_in;
			repeat (BIT_CLKS) @(posedge core_clk_in);
		end
	endtask

	// sync byte put on the line after each falling shift clock
	task automatic ssend(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge sclk_in);
			#1 line_out = b[i];
		end
		@(posedge sclk_in);
		#1 line_out = 1'h1;
	endtask

	// sync byte taken on each rising shift clock
	task automatic srecv(output logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sclk_in);
			b[i] = sdat_in;
		end
	endtask
endmodule

/* File: verif/test_acss_channel.sv */
// testbench: async, parity, wake, loop-back and sync transfers
`timescale 1ns/100ps
module test_acss_channel import acss_pkg::*;;
	logic        core_clk_in;
	logic        rst_n_in;
	acss_cfg_s   cfg_in;
	acss_word_t  tx_data_in;
	logic        tx_valid_in;
	logic        tx_ready_out;
	acss_word_t  rx_data_out;
	logic        rx_full_out;
	logic        rx_read_in;
	acss_err_s   err_out;
	logic        err_clr_in;
	acss_irq_s   irq_out;
	logic        txd_out;
	logic        rxd_in;
	logic        rxd_out;
	logic        rxd_oe_out;
	logic [10:0] raw;
	acss_word_t  d;
	logic [7:0]  sb;
	logic        nb;
	int          n;
	int          checks;
	int          miscompares;

	acss_channel acss_channel_inst (.*);
	// second instance only feeds the bound checker
	acss_channel #(.SECONDARY(1'b1)) acss_channel_sec_inst (.core_clk_in,
		.rst_n_in, .cfg_in, .tx_data_in, .tx_valid_in, .rx_read_in,
		.err_clr_in, .rxd_in, .tx_ready_out(), .rx_data_out(),
		.rx_full_out(), .err_out(), .irq_out(), .txd_out(), .rxd_out(),
		.rxd_oe_out());
	acss_partner #(.BIT_CLKS(48)) acss_partner_inst (.core_clk_in,
		.line_in(txd_out), .sclk_in(txd_out), .sdat_in(rxd_out),
		.line_out(rxd_in));

	// 25 ns clock
	initial
	begin
		core_clk_in = 1'h0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end

	task automatic stop_test();
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [10:0] e,
		input logic [10:0] g);
		checks++;
		if (g !== e)
		begin
			$display("mismatch %s exp %h got %h", nm, e, g);
			miscompares++;
		end
	endtask

	// inputs set after this task move 1 ns after the edge
	task automatic tick(input int c);
		repeat (c) @(posedge core_clk_in);
		#1;
	endtask

	task automatic put(input acss_word_t w);
		tick(1);
		tx_data_in = w;
		tx_valid_in = 1'h1;
		tick(1);
		tx_valid_in = 1'h0;
		chk("ready", 11'h0, tx_ready_out);
	endtask

	// read and flag clear together, one cycle
	task automatic clr();
		tick(1);
		rx_read_in = 1'h1;
		err_clr_in = 1'h1;
		tick(1);
		rx_read_in = 1'h0;
		err_clr_in = 1'h0;
	endtask

	task automatic rx8(input logic [8:0] f, input int len);
		acss_partner_inst.send({1'h1, f, 1'h0}, len);
		tick(2);
	endtask

	// a hung handshake ends the run as a failure
	initial
	begin
		repeat (40000) @(posedge core_clk_in);
		miscompares++;
		stop_test();
	end

	initial
	begin
		{tx_data_in, tx_valid_in, rx_read_in, err_clr_in} = '0;
		cfg_in = '0;
		cfg_in.mode = ACSS_ASYNC8;
		cfg_in.frm_chk = 1'h1;
		cfg_in.rx_en = 1'h1;
		cfg_in.reload = 13'h0002;
		rst_n_in = 1'h0;
		tick(16);
		rst_n_in = 1'h1;
		chk("idle", 11'h042, {tx_ready_out, rx_full_out, err_out, txd_out,
			rxd_oe_out});
		// five transmit formats: plain, even, odd, nine bits, wake
		for (int k = 0; k < 5; k++)
		begin
			d = {!k[0], 8'hA5 + k[7:0]};
			cfg_in.mode = k < 3 ? ACSS_ASYNC8 : ACSS_ASYNC9;
			if (k == 4)
				cfg_in.mode = ACSS_ASYNC_WAKE;
			cfg_in.par_en = k inside {1, 2};
			cfg_in.par_odd = k == 2;
			nb = cfg_in.par_en ? ^d[7:0] ^ cfg_in.par_odd : d[8];
			n = k == 0 ? 10 : 11;
			fork
				put(d);
				acss_partner_inst.recv(raw, n);
			join
			chk("tx frame", n == 10 ? {2'h1, d[7:0], 1'h0}
				: {1'h1, nb, d[7:0], 1'h0}, raw);
		end
		cfg_in = '{ACSS_ASYNC8, 1, 0, 0, 1, 0, 1, 1, 13'h0002};
		put(9'h096);
		for (int i = 0; i < 2000 && rx_full_out !== 1'h1; i++)
			tick(1);
		chk("loop", 11'h296, {rx_full_out, rx_data_out});
		cfg_in.loop = 1'h0;
		clr();
		rx8(9'h13C, 10);
		chk("rx", 11'h23C, {rx_full_out, rx_data_out});
		rx8(9'h1C3, 10);
		chk("overrun", 11'h2C3, {err_out.ovr, rx_data_out});
		clr();
		chk("cleared", 11'h0, {rx_full_out, err_out});
		cfg_in.par_en = 1'h1;
		for (int p = 0; p < 2; p++)
		begin
			rx8({p[0], 8'h07}, 11);
			chk("parity", 11'(p == 0), err_out.par);
			clr();
		end
		cfg_in.par_en = 1'h0;
		rx8(9'h05A, 10);
		chk("framing", 11'h1, err_out.frm);
		clr();
		cfg_in.mode = ACSS_ASYNC_WAKE;
		cfg_in.wake_filt = 1'h1;
		rx8(9'h011, 11);
		chk("filtered", 11'h0, rx_full_out);
		rx8(9'h122, 11);
		chk("address", 11'h322, {rx_full_out, rx_data_out});
		clr();
		cfg_in = '{ACSS_SYNC8, 0, 0, 0, 0, 0, 0, 0, 13'h0005};
		fork
			put(9'h0C3);
			acss_partner_inst.srecv(sb);
		join
		chk("sync byte", 11'h0C3, sb);
		// sync receive: the channel clocks, the partner drives the pin
		tick(1);
		fork
			cfg_in.rx_en = 1'h1;
			acss_partner_inst.ssend(8'h5D);
		join
		cfg_in.rx_en = 1'h0;
		chk("sync rx", 11'h25D, {rx_full_out, rx_data_out});
		stop_test();
	end
endmodule
